// ---- design/scss_div_if.sv ----
`timescale 1ns/10ps
interface scss_div_if #(parameter int W = 9);
  logic [W-1:0] div;
  logic inTick;
  logic outTick;
  modport ctl (output div, output inTick, input outTick);
  modport dv (input div, input inTick, output outTick);
endinterface : scss_div_if

// ---- design/scss_pkg.sv ----
package scss_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TUNE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;
  // CTRL fields
  localparam int CTRL_IDLE = 7;
  localparam int CTRL_IFS = 4;
  localparam int CTRL_SEL = 0;
  // TUNE fields
  localparam int TUNE_LFS = 7;
  // STAT fields
  localparam int STAT_SW = 0;
  localparam int STAT_FST = 2;
  localparam int STAT_OST = 3;
  localparam int STAT_SEC = 6;
  // CFG readback fields
  localparam int CFG_MODE = 0;
  localparam int CFG_PLL = 4;
  localparam int CFG_CPU = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [2:0] IFS_RST = 3'h6;
  localparam logic IDLE_RST = 1'b0;
  localparam logic LFS_RST = 1'b0;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_RSV = 2'h2;
  localparam logic [1:0] SEL_INT = 2'h3;
  localparam logic [2:0] IFS_LOW = 3'h0;
  localparam logic [2:0] IFS_TOP = 3'h7;
  localparam logic [8:0] LOW_DIV = 9'h100;
  localparam logic [2:0] MODE_INT = 3'h0;
  localparam logic [2:0] MODE_INT_PLL = 3'h1;
  localparam logic [2:0] MODE_XTAL = 3'h2;
  localparam logic [2:0] MODE_XTAL_PLL = 3'h3;
  localparam logic [2:0] MODE_EXT = 3'h4;
  localparam logic [2:0] MODE_EXT_PLL = 3'h5;
  // ----------------------------------------
  // Counts
  // ----------------------------------------
  localparam int OST_TICKS = 1024;
  localparam int OLD_TICKS = 2;
  localparam int NEW_TICKS = 3;
  typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} scss_sw_t;
endpackage : scss_pkg

// ---- design/scss_switch.sv ----
`timescale 1ns/10ps
module scss_switch import scss_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [1:0] target,
  input wire logic [3:0] srcTick,
  output logic sysTick,
  output logic [1:0] active,
  output logic switching
);
  typedef struct packed {
    scss_sw_t st;
    logic [1:0] act;
    logic [1:0] cnt;
    logic tick;
  } scss_sw_st_t;
  scss_sw_st_t s_q, s_d;

  // ----------------------------------------
  // Glitch-free hand-over
  // ----------------------------------------
  // Clock is held off for old ticks then new ticks; a dead new source stalls here
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    case (s_q.st)
      SW_RUN: begin
        s_d.tick = srcTick[s_q.act];
        if (target != s_q.act) begin
          s_d.st = SW_OLD;
          s_d.cnt = 2'h0;
          s_d.tick = 1'b0;
        end
      end
      SW_OLD: begin
        if (srcTick[s_q.act]) begin
          if (s_q.cnt == 2'(OLD_TICKS - 1)) begin
            s_d.st = SW_NEW;
            s_d.cnt = 2'h0;
          end else begin
            s_d.cnt = s_q.cnt + 2'h1;
          end
        end
      end
      SW_NEW: begin
        if (srcTick[target]) begin
          if (s_q.cnt == 2'(NEW_TICKS - 1)) begin
            s_d.st = SW_RUN;
            s_d.act = target;
          end else begin
            s_d.cnt = s_q.cnt + 2'h1;
          end
        end
      end
      default: s_d.st = SW_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{st: SW_RUN, act: SEL_PRI, cnt: 2'h0, tick: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sysTick = s_q.tick;
  assign active = s_q.act;
  assign switching = (s_q.st != SW_RUN);

  a_no_tick_switch: assert property (@(posedge clk) disable iff (!nrst)
    switching |-> !sysTick) else $error("clock tick during switch");
  a_old_first: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_q.st == SW_RUN && target != s_q.act |=> s_q.st == SW_OLD)
    else $error("switch did not start");
endmodule : scss_switch

// ---- design/scss_tick_div.sv ----
`timescale 1ns/10ps
module scss_tick_div import scss_pkg::*; #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  scss_div_if.dv port
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } scss_div_st_t;
  scss_div_st_t s_q, s_d;
  logic [W-1:0] lim;

  initial begin
    if (W < 2) $error("scss_tick_div: W below 2");
  end

  // Divisor 0 behaves as 1; a shrinking divisor takes effect at once
  assign lim = (port.div == '0) ? '0 : port.div - {{(W-1){1'b0}}, 1'b1};

  always_comb begin
    s_d = s_q;
    s_d.out = 1'b0;
    if (port.inTick) begin
      if (s_q.cnt >= lim) begin
        s_d.cnt = '0;
        s_d.out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign port.outTick = s_q.out;
endmodule : scss_tick_div

// ---- design/scss_top.sv ----
`timescale 1ns/10ps
// Behaviour
// - Fast internal osc may feed the PLL
// - Select primary, secondary or postscaled internal
// - Source switch starts at once after write
// - Every reset clears source select
// - Frequency select picks slow, fast, or tap
// - Frequency select change acts immediately
// - Postscaler resets to 4 MHz
// - Code 000: low-freq select picks source
// - Slow RC always clocks watchdog
// - Start-up done: timer expired, primary active
// - Secondary active flag while secondary clocks
// - At most one running flag set
// - Sleep enters idle or full sleep
// - Secondary select ignored without driver/digital
// - Secondary keeps running in power-managed modes
// - Primary mode fixed by configuration field
// - Select codes 11 int, 01 sec, 00 pri
// - 111 8 MHz, halving down, 000 31 kHz
// - Switch pauses two old, three new ticks
module scss_top import scss_pkg::*; #(
  parameter int OST_N = OST_TICKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primaryOscIn,
  input wire logic secondaryOscIn,
  input wire logic slowRcIn,
  input wire logic fastOscIn,
  input wire logic fastOscStable,
  input wire logic [2:0] primaryModeConfig,
  input wire logic [2:0] pllInputDivider,
  input wire logic [1:0] cpuClockDivider,
  input wire logic secondaryDigitalInputConfig,
  input wire logic secondaryCrystalDriverEnable,
  input wire logic sleepCmd,
  input wire logic wakeCmd,
  output logic sysClkTick,
  output logic cpuClkTick,
  output logic wdtClkTick,
  output logic pllRefTick,
  output logic primaryOscEnable,
  output logic secondaryOscEnable,
  output logic idleMode,
  output logic sleepMode
);
  localparam int OW = $clog2(OST_N + 1);
  localparam int CW = 11;

  initial begin
    if (OST_N < 1) $error("scss_top: OST_N below 1");
  end

  typedef struct packed {
    logic [3:0] oscS1;
    logic [3:0] oscS2;
    logic [3:0] oscS3;
    logic [CW-1:0] cfgS1;
    logic [CW-1:0] cfgS2;
    logic [1:0] cfgCnt;
    logic [2:0] mode;
    logic [2:0] pll_input_divider;
    logic [1:0] cpuDiv;
    logic idleOnSleep;
    logic [2:0] ifs;
    logic [1:0] sel;
    logic lfs;
    logic [OW-1:0] start_up_timer;
    logic idle;
    logic sleep;
    logic rdy;
    logic [31:0] rdata;
  } scss_top_st_t;
  scss_top_st_t s_q, s_d;

  // ----------------------------------------
  // Synchronised pins
  // ----------------------------------------
  logic [3:0] oscEdge;
  logic [CW-1:0] cfgNow;
  logic digCfg;
  logic xtalEn;
  logic fastOk;
  assign oscEdge = s_q.oscS2 & ~s_q.oscS3;
  assign cfgNow = {primaryModeConfig, pllInputDivider, cpuClockDivider,
                   secondaryDigitalInputConfig, secondaryCrystalDriverEnable,
                   fastOscStable};
  assign digCfg = s_q.cfgS2[2];
  assign xtalEn = s_q.cfgS2[1];
  assign fastOk = s_q.cfgS2[0];

  // Oscillator edges after sync; index 0 pri, 1 sec, 2 slow RC, 3 fast
  logic priEdge, secEdge, rcEdge, fastEdge;
  assign priEdge = oscEdge[0];
  assign secEdge = oscEdge[1];
  assign rcEdge = oscEdge[2];
  assign fastEdge = oscEdge[3];

  // ----------------------------------------
  // Postscaler, PLL input and CPU dividers
  // ----------------------------------------
  scss_div_if #(.W(9)) postIf ();
  scss_div_if #(.W(9)) pllIf ();
  scss_div_if #(.W(9)) cpuIf ();
  logic intTick;
  logic intMode;
  logic pllMode;

  always_comb begin
    postIf.inTick = fastEdge;
    postIf.div = 9'h001 << (IFS_TOP - s_q.ifs);
    if (s_q.ifs == IFS_LOW) begin
      postIf.div = LOW_DIV;
    end
  end
  scss_tick_div #(.W(9)) uPost (.clk(clk), .nrst(nrst), .ce(ce), .port(postIf));
  // Low-frequency option picks slow RC or fast osc divided by 256
  assign intTick = (s_q.ifs == IFS_LOW && !s_q.lfs) ? rcEdge : postIf.outTick;

  assign intMode = (s_q.mode == MODE_INT) || (s_q.mode == MODE_INT_PLL);
  assign pllMode = (s_q.mode == MODE_INT_PLL) || (s_q.mode == MODE_XTAL_PLL)
                   || (s_q.mode == MODE_EXT_PLL);

  always_comb begin
    pllIf.inTick = (s_q.mode == MODE_INT_PLL) ? fastEdge : priEdge;
    case (s_q.pll_input_divider)
      3'h3: pllIf.div = 9'h005;
      3'h4: pllIf.div = 9'h004;
      3'h5: pllIf.div = 9'h003;
      3'h6: pllIf.div = 9'h002;
      default: pllIf.div = 9'h001;
    endcase
  end
  scss_tick_div #(.W(9)) uPll (.clk(clk), .nrst(nrst), .ce(ce), .port(pllIf));

  always_comb begin
    cpuIf.inTick = priEdge;
    case (s_q.cpuDiv)
      2'h3: cpuIf.div = 9'h001;
      2'h2: cpuIf.div = 9'h002;
      2'h1: cpuIf.div = 9'h003;
      default: cpuIf.div = 9'h006;
    endcase
  end
  scss_tick_div #(.W(9)) uCpu (.clk(clk), .nrst(nrst), .ce(ce), .port(cpuIf));

  // ----------------------------------------
  // Source switch
  // ----------------------------------------
  logic [3:0] srcTick;
  logic swTick;
  logic [1:0] active;
  logic switching;
  // Internal primary modes run from the postscaler; others from the CPU divider
  assign srcTick = {intTick, 1'b0, secEdge, intMode ? intTick : cpuIf.outTick};
  scss_switch uSw (.clk(clk), .nrst(nrst), .ce(ce), .target(s_q.sel),
    .srcTick(srcTick), .sysTick(swTick), .active(active), .switching(switching));

  // ----------------------------------------
  // Register bus and control
  // ----------------------------------------
  logic wrEn;
  logic mapped;
  logic [31:0] rdMux;
  logic priRun;
  logic secRun;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_TUNE)
                  || (paddr == ADDR_STAT) || (paddr == ADDR_CFG);
  assign wrEn = psel && penable && pready && pwrite;
  assign priRun = (s_q.start_up_timer == OW'(OST_N)) && active == SEL_PRI && !switching;
  assign secRun = active == SEL_SEC && !switching;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL: begin
        rdMux[CTRL_IDLE] = s_q.idleOnSleep;
        rdMux[CTRL_IFS +: 3] = s_q.ifs;
        rdMux[CTRL_SEL +: 2] = s_q.sel;
      end
      ADDR_TUNE: rdMux[TUNE_LFS] = s_q.lfs;
      ADDR_STAT: begin
        rdMux[STAT_SW] = switching;
        rdMux[STAT_FST] = fastOk;
        rdMux[STAT_OST] = priRun;
        rdMux[STAT_SEC] = secRun;
      end
      ADDR_CFG: begin
        rdMux[CFG_MODE +: 3] = s_q.mode;
        rdMux[CFG_PLL +: 3] = s_q.pll_input_divider;
        rdMux[CFG_CPU +: 2] = s_q.cpuDiv;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.oscS1 = {fastOscIn, slowRcIn, secondaryOscIn, primaryOscIn};
    s_d.oscS2 = s_q.oscS1;
    s_d.oscS3 = s_q.oscS2;
    s_d.cfgS1 = cfgNow;
    s_d.cfgS2 = s_q.cfgS1;
    // Straps are caught once, on the third edge, when the synchroniser holds them
    if (s_q.cfgCnt != 2'h3) begin
      s_d.cfgCnt = s_q.cfgCnt + 2'h1;
    end
    if (s_q.cfgCnt == 2'h2) begin
      s_d.mode = s_q.cfgS2[10:8];
      s_d.pll_input_divider = s_q.cfgS2[7:5];
      s_d.cpuDiv = s_q.cfgS2[4:3];
    end
    // Bus: load read data in setup, answer in access
    if (psel && !penable) begin
      s_d.rdata = rdMux;
      s_d.rdy = 1'b1;
    end else if (psel && penable && pready) begin
      s_d.rdy = 1'b0;
    end
    if (wrEn && paddr == ADDR_CTRL) begin
      s_d.idleOnSleep = pwdata[CTRL_IDLE];
      s_d.ifs = pwdata[CTRL_IFS +: 3];
      // Reserved code and an unready secondary leave the selection alone
      if (pwdata[CTRL_SEL +: 2] == SEL_SEC) begin
        if (xtalEn || digCfg) begin
          s_d.sel = SEL_SEC;
        end
      end else if (pwdata[CTRL_SEL +: 2] != SEL_RSV) begin
        s_d.sel = pwdata[CTRL_SEL +: 2];
      end
    end
    if (wrEn && paddr == ADDR_TUNE) begin
      s_d.lfs = pwdata[TUNE_LFS];
    end
    // Start-up timer counts primary edges while that oscillator is on
    if (s_q.sleep) begin
      s_d.start_up_timer = '0;
    end else if (priEdge && s_q.start_up_timer != OW'(OST_N)) begin
      s_d.start_up_timer = s_q.start_up_timer + OW'(1);
    end
    if (wakeCmd) begin
      s_d.idle = 1'b0;
      s_d.sleep = 1'b0;
    end else if (sleepCmd) begin
      s_d.idle = s_q.idleOnSleep;
      s_d.sleep = !s_q.idleOnSleep;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.sel <= SEL_RST;
      s_q.ifs <= IFS_RST;
      s_q.idleOnSleep <= IDLE_RST;
      s_q.lfs <= LFS_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s_q.rdata;
  assign pready = ce && s_q.rdy;
  assign pslverr = psel && penable && !mapped;
  assign sysClkTick = swTick && !s_q.sleep;
  assign cpuClkTick = sysClkTick && !s_q.idle;
  assign wdtClkTick = rcEdge;
  assign pllRefTick = pllMode && pllIf.outTick;
  assign primaryOscEnable = !s_q.sleep;
  // Secondary never stops for sleep so a wake timer keeps counting
  assign secondaryOscEnable = xtalEn || s_q.sel == SEL_SEC;
  assign idleMode = s_q.idle;
  assign sleepMode = s_q.sleep;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sel_reset: assert property (@(posedge clk)
    !nrst |=> s_q.sel == SEL_PRI && s_q.ifs == IFS_RST) else $error("bad reset");
  a_sec_refused: assert property (@(posedge clk) disable iff (!nrst)
    ce && wrEn && paddr == ADDR_CTRL && pwdata[1:0] == SEL_SEC && !xtalEn && !digCfg
    |=> s_q.sel == $past(s_q.sel)) else $error("secondary taken");
  a_sleep_kind: assert property (@(posedge clk) disable iff (!nrst)
    ce && sleepCmd && !wakeCmd |=> idleMode == $past(s_q.idleOnSleep)
    && sleepMode == !$past(s_q.idleOnSleep)) else $error("wrong sleep kind");
  a_one_run: assert property (@(posedge clk) disable iff (!nrst)
    !(priRun && secRun)) else $error("two running flags");
  a_sec_flag: assert property (@(posedge clk) disable iff (!nrst)
    secRun |-> active == SEL_SEC && !switching) else $error("sec flag wrong");
  a_wdt_rc: assert property (@(posedge clk) disable iff (!nrst)
    wdtClkTick == (s_q.oscS2[2] && !s_q.oscS3[2])) else $error("wdt clock");
  // The select register moves a cycle before the switch engine, so check the live source
  a_ost_flag: assert property (@(posedge clk) disable iff (!nrst)
    priRun |-> s_q.start_up_timer == OW'(OST_N) && active == SEL_PRI) else $error("ost");
  a_top_div: assert property (@(posedge clk) disable iff (!nrst)
    s_q.ifs == IFS_TOP |-> postIf.div == 9'h001) else $error("8 MHz div");
  a_sec_on: assert property (@(posedge clk) disable iff (!nrst)
    s_q.sel == SEL_SEC |-> secondaryOscEnable) else $error("sec osc off");

  c_switch_sec: cover property (@(posedge clk) disable iff (!nrst) secRun);
  c_switch_int: cover property (@(posedge clk) disable iff (!nrst)
    active == SEL_INT && !switching);
  c_idle: cover property (@(posedge clk) disable iff (!nrst) idleMode);
  c_refused: cover property (@(posedge clk) disable iff (!nrst)
    wrEn && paddr == ADDR_CTRL && pwdata[1:0] == SEL_SEC && !xtalEn && !digCfg);
endmodule : scss_top

// ---- tb/tb_scss_top.sv ----
`timescale 1ns/10ps
module tb_scss_top import scss_pkg::*; ();
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  typedef struct {logic [31:0] v; logic e; bit chk; string what;} scss_note_t;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic pready, pslverr, priIn = 1'b0, secIn = 1'b0, rcIn = 1'b0, fastIn = 1'b0;
  logic fastOk = 1'b1, digCfg = 1'b0, drvEn = 1'b0, sleepCmd = 1'b0, wakeCmd = 1'b0;
  logic [2:0] modeCfg = MODE_XTAL, pll_input_divider = 3'h7;
  logic [1:0] cpuDiv = 2'h3;
  logic sysClkTick, cpuClkTick, wdtClkTick, pllRefTick, priEn, secEn, idleMode, sleepMode;
  int failCount = 0, samplesChecked = 0, cycles = 0, oscCnt = 0, seed = 96894, gap;
  scss_note_t notes[$];

  scss_top #(.OST_N(4)) scss_top_i (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primaryOscIn(priIn), .secondaryOscIn(secIn),
    .slowRcIn(rcIn), .fastOscIn(fastIn), .fastOscStable(fastOk),
    .primaryModeConfig(modeCfg), .pllInputDivider(pll_input_divider), .cpuClockDivider(cpuDiv),
    .secondaryDigitalInputConfig(digCfg), .secondaryCrystalDriverEnable(drvEn),
    .sleepCmd(sleepCmd), .wakeCmd(wakeCmd), .sysClkTick(sysClkTick),
    .cpuClkTick(cpuClkTick), .wdtClkTick(wdtClkTick), .pllRefTick(pllRefTick),
    .primaryOscEnable(priEn), .secondaryOscEnable(secEn), .idleMode(idleMode),
    .sleepMode(sleepMode));

  always #50 clk = ~clk;

  // Oscillator periods in clk cycles: primary 8, fast 4, slow RC 32, secondary 20
  always @(posedge clk) begin
    oscCnt <= oscCnt + 1;
    priIn <= oscCnt[2];
    fastIn <= oscCnt[1];
    rcIn <= oscCnt[4];
    secIn <= (oscCnt % 20) < 10;
  end

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : printVerdict

  // Monitor: every completed transfer consumes the oldest note
  always @(posedge clk) begin
    scss_note_t n;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected transfer", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        if (n.chk) check(n.what, prdata, n.v);
        check({n.what, " error"}, {31'h0, pslverr}, {31'h0, n.e});
      end
    end
  end

  // Long ceiling: the slowest step waits three 1024-cycle ticks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failCount++;
      printVerdict();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] exp, input bit chk, input logic err, input string what,
      output logic [31:0] rdat);
    scss_note_t n;
    n.v = exp;
    n.e = err;
    n.chk = chk;
    n.what = what;
    notes.push_back(n);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 32'h0, 1'b0, 1'b0, "write", r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, exp, 1'b1, 1'b0, what, r);
  endtask : rd

  // Poll until the switch engine is back in run, bounded by the tries
  task automatic settle();
    logic [31:0] r;
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, ADDR_STAT, 32'h0, 32'h0, 1'b0, 1'b0, "poll", r);
      if (r[STAT_SW] === 1'b0) break;
    end
  endtask : settle

  function automatic logic pick(input int w);
    return (w == 0) ? sysClkTick : (w == 1) ? wdtClkTick : pllRefTick;
  endfunction : pick

  // First two ticks skipped so a change in flight has landed
  task automatic tickGap(input int which, output int n);
    int k;
    k = 0;
    n = 0;
    while (k < 3) begin
      @(negedge clk);
      n++;
      if (pick(which) === 1'b1) begin
        k++;
        if (k < 3) n = 0;
      end
    end
  endtask : tickGap

  task automatic pulse(input logic wake);
    @(posedge clk);
    sleepCmd <= !wake;
    wakeCmd <= wake;
    @(posedge clk);
    sleepCmd <= 1'b0;
    wakeCmd <= 1'b0;
    @(negedge clk);
  endtask : pulse

  task automatic doReset(input logic [2:0] m);
    modeCfg <= m;
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : doReset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    logic [31:0] r;
    cpuDiv <= 2'($random(seed));
    pll_input_divider <= 3'(3 + ($unsigned($random(seed)) % 5));
    doReset(MODE_XTAL);
    rd(ADDR_CTRL, 32'h00000060, "ctrl reset");
    rd(ADDR_TUNE, 32'h00000000, "tune reset");
    rd(ADDR_CFG, {22'h0, cpuDiv, 1'b0, pll_input_divider, 1'b0, modeCfg}, "cfg");
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1, 1'b1, "unmapped", r);
    tickGap(1, gap);
    check("watchdog gap", 32'(gap), 32'd32);
    tickGap(0, gap);
    check("primary gap", 32'(gap), 32'(8 * ((cpuDiv == 2'h3) ? 1 : (cpuDiv == 2'h2) ? 2 :
      (cpuDiv == 2'h1) ? 3 : 6)));
    rd(ADDR_STAT, 32'h0000000C, "stat primary");
    for (k = 7; k >= 1; k--) begin
      wr(ADDR_CTRL, 32'(k * 16 + 3));
      tickGap(0, gap);
      check("postscaled gap", 32'(gap), 32'(4 << (7 - k)));
    end
    wr(ADDR_TUNE, 32'h00000080);
    wr(ADDR_CTRL, 32'h00000003);
    tickGap(0, gap);
    check("divided low gap", 32'(gap), 32'd1024);
    wr(ADDR_TUNE, 32'h00000000);
    tickGap(0, gap);
    check("slow rc gap", 32'(gap), 32'd32);
    rd(ADDR_STAT, 32'h00000004, "stat internal");
    wr(ADDR_CTRL, 32'h00000002);
    rd(ADDR_CTRL, 32'h00000003, "reserved select");
    wr(ADDR_CTRL, 32'h00000001);
    rd(ADDR_CTRL, 32'h00000003, "secondary refused");
    digCfg <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 32'h00000001);
    rd(ADDR_CTRL, 32'h00000001, "secondary taken");
    settle();
    rd(ADDR_STAT, 32'h00000044, "stat secondary");
    tickGap(0, gap);
    check("secondary gap", 32'(gap), 32'd20);
    @(posedge clk);
    drvEn <= 1'b1;
    digCfg <= 1'b0;
    wr(ADDR_CTRL, 32'h00000081);
    pulse(1'b0);
    check("idle entry", {30'h0, idleMode, sleepMode}, 32'h2);
    pulse(1'b1);
    check("idle exit", {30'h0, idleMode, sleepMode}, 32'h0);
    wr(ADDR_CTRL, 32'h00000001);
    pulse(1'b0);
    check("sleep entry", {30'h0, idleMode, sleepMode}, 32'h1);
    check("osc enables", {30'h0, priEn, secEn}, 32'h1);
    pulse(1'b1);
    // Clock enable low: a sleep request in that time must be lost
    @(posedge clk);
    ce <= 1'b0;
    sleepCmd <= 1'b1;
    @(posedge clk);
    sleepCmd <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    check("frozen sleep", {30'h0, idleMode, sleepMode}, 32'h0);
    // Second reset in mid-run with a PLL mode strapped
    @(posedge clk);
    doReset(MODE_XTAL_PLL);
    rd(ADDR_CTRL, 32'h00000060, "ctrl second reset");
    rd(ADDR_CFG, {22'h0, cpuDiv, 1'b0, pll_input_divider, 1'b0, modeCfg}, "cfg pll");
    tickGap(2, gap);
    check("pll ref gap", 32'(gap), 32'(8 * (8 - int'(pll_input_divider))));
    // Third reset: internal oscillator feeds the PLL and the primary path
    @(posedge clk);
    doReset(MODE_INT_PLL);
    tickGap(2, gap);
    check("int pll ref gap", 32'(gap), 32'(4 * (8 - int'(pll_input_divider))));
    tickGap(0, gap);
    check("int primary gap", 32'(gap), 32'd8);
    printVerdict();
  end
endmodule : tb_scss_top
